// ==== rtl/emt_bus_seq.v ====
// External static memory bus cycle sequencer.
// Overview of operation
// RQ1: Each phase is a fixed quarter fraction plus one period per wait count.
// RQ2: Write timing differs when the write active wait count is zero.
// RQ3: With zero write active waits, strobe asserts half period plus setup.
// RQ4: Write data stays driven a quarter period plus hold waits after strobe.
// RQ5: Address stays valid a quarter period plus hold waits after write.
// RQ6: Read strobe asserts with the address, delayed by read setup waits.
// RQ7: Read strobe drops one period plus setup and active waits later.
// RQ8: Address holds after read strobe for read hold waits only.
// RQ9: Read data is sampled on the edge that deasserts the read strobe.
// RQ10: Memory must present data by the read strobe deassertion edge.
// RQ11: Write to read gap is quarter period plus write hold, read setup.
// RQ12: Read to read strobe gap is read setup plus read hold periods.
// RQ13: With zero read setup and hold, back-to-back reads keep strobe low.
// RQ14: Write to write gap is three quarters or one period plus waits.
// RQ15: Read to write gap adds half or three quarters period, waits and turnaround controls.
// RQ16: Address lines do not change while no external cycle runs.
// RQ17: Wait counts come from configuration inputs held until rewritten.
`timescale 1ns/1ns
`include "emt_defines.vh"

module emt_bus_seq #(
	parameter AW = `EMT_ADDR_W,
	parameter DW = `EMT_DATA_W,
	parameter WW = `EMT_WAIT_W
) (
	// Clock and reset
	input  wire          core_clk_i,
	input  wire          rst_n_i,
	// Wait-state configuration
	input  wire [WW-1:0] read_setup_waits_i,
	input  wire [WW-1:0] read_active_waits_i,
	input  wire [WW-1:0] read_hold_waits_i,
	input  wire [WW-1:0] write_setup_waits_i,
	input  wire [WW-1:0] write_active_waits_i,
	input  wire [WW-1:0] write_hold_waits_i,
	input  wire [WW-1:0] turnaround_delay_ctl_i,
	input  wire [WW-1:0] base_turnaround_delay_ctl_i,
	// Request side
	input  wire          req_valid_i,
	input  wire          req_write_i,
	input  wire [AW-1:0] req_addr_i,
	input  wire [DW-1:0] req_wdata_i,
	output reg           req_taken_o,
	output reg           busy_o,
	output reg  [DW-1:0] rdata_o,
	output reg           rdata_valid_o,
	// Memory pins
	output reg  [AW-1:0] mem_addr_o,
	output reg  [DW-1:0] mem_data_o,
	output reg           mem_data_oe_o,
	input  wire [DW-1:0] mem_data_i,
	output reg           mem_rd_n_o,
	output reg           mem_wr_n_o
);

	localparam LW = `EMT_LEN_W;
	localparam [2:0] S_IDLE  = `EMT_S_IDLE;
	localparam [2:0] S_TURN  = `EMT_S_TURN;
	localparam [2:0] S_SETUP = `EMT_S_SETUP;
	localparam [2:0] S_ACT   = `EMT_S_ACT;
	localparam [2:0] S_HOLD  = `EMT_S_HOLD;

	// ============================================================
	// State
	// ============================================================
	reg  [2:0]    state;
	reg  [LW-1:0] cnt;
	reg           cur_wr;
	reg           prev_rd;
	reg  [AW-1:0] cur_addr;
	reg  [DW-1:0] cur_wdata;
	reg  [LW-1:0] l_setup;
	reg  [LW-1:0] l_act;
	reg  [LW-1:0] l_hold;

	reg  [2:0]    next_state;
	reg  [LW-1:0] next_cnt;
	reg           start;
	reg           cyc_end;
	reg           next_wr;
	reg           addr_load;

	wire [LW-1:0] c_turn;
	wire [LW-1:0] c_setup;
	wire [LW-1:0] c_act;
	wire [LW-1:0] c_hold;

	// Lengths follow the live configuration; they are latched at the
	// start of each cycle so a rewrite never tears a running cycle.
	emt_len_calc #(
		.WW (WW),
		.LW (LW)
	) u_len (
		.wr_i        (req_write_i),
		.prev_rd_i   (prev_rd),
		.rss_i       (read_setup_waits_i),
		.ras_i       (read_active_waits_i),
		.rsh_i       (read_hold_waits_i),
		.wss_i       (write_setup_waits_i),
		.was_i       (write_active_waits_i),
		.wsh_i       (write_hold_waits_i),
		.turn_i      (turnaround_delay_ctl_i),
		.base_turn_i (base_turnaround_delay_ctl_i),
		.turn_len_o  (c_turn),
		.setup_len_o (c_setup),
		.act_len_o   (c_act),
		.hold_len_o  (c_hold)
	);

	// ============================================================
	// Phase helpers
	// ============================================================
	// Next phase after st, skipping phases of zero length.
	function [2:0] follow;
		input [2:0]    st;
		input [LW-1:0] ls;
		input [LW-1:0] lh;
		begin
			case (st)
				S_TURN:  follow = (ls != {LW{1'b0}}) ? S_SETUP : S_ACT;
				S_SETUP: follow = S_ACT;
				S_ACT:   follow = (lh != {LW{1'b0}}) ? S_HOLD : S_IDLE;
				default: follow = S_IDLE;
			endcase
		end
	endfunction

	function [LW-1:0] len_of;
		input [2:0]    st;
		input [LW-1:0] lt;
		input [LW-1:0] ls;
		input [LW-1:0] la;
		input [LW-1:0] lh;
		begin
			case (st)
				S_TURN:  len_of = lt;
				S_SETUP: len_of = ls;
				S_ACT:   len_of = la;
				S_HOLD:  len_of = lh;
				default: len_of = {LW{1'b0}};
			endcase
		end
	endfunction

	// ============================================================
	// Next-state logic
	// ============================================================
	always @* begin
		next_state = state;
		next_cnt   = cnt;
		start      = 1'b0;
		cyc_end    = 1'b0;
		if (state != S_IDLE) begin
			if (cnt != {LW{1'b0}}) begin
				next_cnt = cnt - {{(LW-1){1'b0}}, 1'b1};
			end else begin
				next_state = follow(state, l_setup, l_hold);
				if (next_state == S_IDLE) begin
					cyc_end = 1'b1;
				end else begin
					next_cnt = len_of(next_state, {LW{1'b0}}, l_setup,
					                  l_act, l_hold) -
					           {{(LW-1){1'b0}}, 1'b1};
				end
			end
		end
		// A new cycle may begin on the very edge the last one ends, so
		// gaps are set only by the hold, turnaround and setup phases.  // see RQ12
		if ((state == S_IDLE || cyc_end) && req_valid_i) begin
			start      = 1'b1;
			next_state = (c_turn != {LW{1'b0}}) ? S_TURN :
			             follow(S_TURN, c_setup, c_hold);
			next_cnt   = len_of(next_state, c_turn, c_setup, c_act,
			                    c_hold) - {{(LW-1){1'b0}}, 1'b1};
		end
		next_wr   = start ? req_write_i : cur_wr;
		// Address moves only when a cycle's address phase begins.
		addr_load = start ? (next_state != S_TURN) :            // see RQ16
		            (state == S_TURN && next_state != S_TURN);
	end

	// ============================================================
	// Sequencer registers
	// ============================================================
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= S_IDLE;
			cnt       <= {LW{1'b0}};
			cur_wr    <= 1'b0;
			prev_rd   <= 1'b0;
			cur_addr  <= `EMT_ADDR_RST;
			cur_wdata <= `EMT_DATA_RST;
			l_setup   <= {LW{1'b0}};
			l_act     <= {LW{1'b0}};
			l_hold    <= {LW{1'b0}};
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			if (start) begin
				cur_wr    <= req_write_i;
				prev_rd   <= !req_write_i;
				cur_addr  <= req_addr_i;
				cur_wdata <= req_wdata_i;
				l_setup   <= c_setup;                           // see RQ17
				l_act     <= c_act;
				l_hold    <= c_hold;
			end
		end
	end

	// ============================================================
	// Pin and user outputs
	// ============================================================
	// Phases in which the write data are driven; the address pins are driven in every phase.  The
	// enable drops with the hold phase, so the data bus is free again
	// by the edge at which a following read strobe can assert.
	function drives;
		input [2:0] st;
		begin
			case (st)
				S_SETUP: drives = 1'b1;
				S_ACT:   drives = 1'b1;
				S_HOLD:  drives = 1'b1;
				default: drives = 1'b0;
			endcase
		end
	endfunction

	reg           next_rd_on;
	reg           next_wr_on;
	reg           next_oe;
	reg           take_data;

	// Pin values are decoded from the next phase so that every pin
	// is a plain flip-flop with no gate behind it.
	always @* begin
		next_rd_on = (next_state == S_ACT) && !next_wr;
		next_wr_on = (next_state == S_ACT) && next_wr;
		next_oe    = next_wr && drives(next_state);
		take_data  = (state == S_ACT) && (cnt == {LW{1'b0}}) && !cur_wr;
	end

	// ============================================================
	// Address and data pins
	// ============================================================
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_addr_o    <= `EMT_ADDR_RST;
			mem_data_o    <= `EMT_DATA_RST;
			mem_data_oe_o <= 1'b0;
		end else begin
			if (addr_load) begin
				mem_addr_o <= start ? req_addr_i : cur_addr;
				if (next_wr) begin
					mem_data_o <= start ? req_wdata_i : cur_wdata;
				end
			end
			// Data and address stay until the hold phase ends.  // see RQ4
			mem_data_oe_o <= next_oe;                          // see RQ5
		end
	end

	// ============================================================
	// Strobe pins
	// ============================================================
	// A read that runs into another read with no setup or hold never
	// lifts its strobe, since the next phase is again the active one.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_rd_n_o <= 1'b1;
			mem_wr_n_o <= 1'b1;
		end else begin
			mem_rd_n_o <= !next_rd_on;                          // see RQ13
			mem_wr_n_o <= !next_wr_on;                          // see RQ14
		end
	end

	// ============================================================
	// User side outputs
	// ============================================================
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_taken_o   <= 1'b0;
			busy_o        <= 1'b0;
			rdata_o       <= `EMT_DATA_RST;
			rdata_valid_o <= 1'b0;
		end else begin
			req_taken_o   <= start;
			busy_o        <= (next_state != S_IDLE);
			// The pins are stable by this edge, so no synchroniser is
			// used; a sync stage would sample after the strobe lifts.
			rdata_valid_o <= 1'b0;
			if (take_data) begin
				rdata_o       <= mem_data_i;                    // see RQ9
				rdata_valid_o <= 1'b1;                          // see RQ10
			end
		end
	end

	// Gaps arise from phase lengths: write hold then read setup gives
	// the write-to-read spacing.  // see RQ11

endmodule

// ==== rtl/emt_defines.vh ====
// Timing constants for the external static memory bus sequencer.
`ifndef EMT_DEFINES_VH
`define EMT_DEFINES_VH

// ============================================================
// Clock and bus period
// ============================================================
`define EMT_CLK_PERIOD_NS  8
`define EMT_BUS_PERIOD_NS  32
// Core clocks per bus period; one core clock is a quarter period.
`define EMT_TPP            (`EMT_BUS_PERIOD_NS / `EMT_CLK_PERIOD_NS)
`define EMT_QUARTER        (`EMT_TPP / 4)
`define EMT_HALF           (`EMT_TPP / 2)
`define EMT_THREE_QUARTER  ((`EMT_TPP * 3) / 4)

// ============================================================
// Widths and reset values
// ============================================================
`define EMT_WAIT_W         4
`define EMT_LEN_W          8
`define EMT_ADDR_W         21
`define EMT_DATA_W         16
`define EMT_ADDR_RST       21'h000000
`define EMT_DATA_RST       16'h0000

// ============================================================
// Sequencer states
// ============================================================
`define EMT_S_IDLE         3'h0
`define EMT_S_TURN         3'h1
`define EMT_S_SETUP        3'h2
`define EMT_S_ACT          3'h3
`define EMT_S_HOLD         3'h4

`endif

// ==== rtl/emt_len_calc.v ====
// Phase length calculator for one external memory bus cycle.
`timescale 1ns/1ns
`include "emt_defines.vh"

module emt_len_calc #(
	parameter WW = `EMT_WAIT_W,
	parameter LW = `EMT_LEN_W
) (
	// Cycle kind
	input  wire          wr_i,
	input  wire          prev_rd_i,
	// Wait counts
	input  wire [WW-1:0] rss_i,
	input  wire [WW-1:0] ras_i,
	input  wire [WW-1:0] rsh_i,
	input  wire [WW-1:0] wss_i,
	input  wire [WW-1:0] was_i,
	input  wire [WW-1:0] wsh_i,
	input  wire [WW-1:0] turn_i,
	input  wire [WW-1:0] base_turn_i,
	// Lengths in core clocks
	output wire [LW-1:0] turn_len_o,
	output wire [LW-1:0] setup_len_o,
	output wire [LW-1:0] act_len_o,
	output wire [LW-1:0] hold_len_o
);

	localparam integer  P_I  = `EMT_TPP;
	localparam integer  Q1_I = `EMT_QUARTER;
	localparam integer  Q2_I = `EMT_HALF;
	localparam integer  Q3_I = `EMT_THREE_QUARTER;
	localparam [LW-1:0] P    = P_I[LW-1:0];
	localparam [LW-1:0] Q1   = Q1_I[LW-1:0];
	localparam [LW-1:0] Q2   = Q2_I[LW-1:0];
	localparam [LW-1:0] Q3   = Q3_I[LW-1:0];

	function [LW-1:0] per;
		input [WW-1:0] w;
		per = P * {{(LW-WW){1'b0}}, w};
	endfunction

	wire was_zero = (was_i == {WW{1'b0}});

	// Fixed quarter fractions plus whole periods per wait.  // see RQ1
	assign setup_len_o = wr_i ? ((was_zero ? Q2 : Q3) + per(wss_i)) // see RQ3
	                          : per(rss_i);                        // see RQ6
	assign act_len_o   = wr_i ? (was_zero ? Q1 : per(was_i))       // see RQ2
	                          : (P + per(ras_i));                  // see RQ7
	assign hold_len_o  = wr_i ? (Q1 + per(wsh_i))                  // see RQ4
	                          : per(rsh_i);                        // see RQ8
	// A write after a read waits the two turnaround controls.
	assign turn_len_o  = (wr_i && prev_rd_i) ?
	                     (per(turn_i) + per(base_turn_i)) :        // see RQ15
	                     {LW{1'b0}};

endmodule

// ==== verif/emt_bus_seq_sva.sv ====
// Concurrent checks on the external memory bus sequencer pins.
`timescale 1ns/1ns
module emt_bus_seq_sva (
	// Clock, reset and request side
	input wire        core_clk_i,
	input wire        rst_n_i,
	input wire        req_write_i,
	input wire        req_taken_o,
	input wire        busy_o,
	input wire        rdata_valid_o,
	// Wait counts
	input wire [3:0]  read_setup_waits_i,
	input wire [3:0]  read_active_waits_i,
	input wire [3:0]  read_hold_waits_i,
	input wire [3:0]  write_setup_waits_i,
	input wire [3:0]  write_active_waits_i,
	input wire [3:0]  write_hold_waits_i,
	input wire [3:0]  turnaround_delay_ctl_i,
	input wire [3:0]  base_turnaround_delay_ctl_i,
	// Memory pins
	input wire [20:0] mem_addr_o,
	input wire [15:0] mem_data_o,
	input wire        mem_data_oe_o,
	input wire        mem_rd_n_o,
	input wire        mem_wr_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Read strobe
	chk_rd_setup: assert property (
		req_taken_o && !$past(req_write_i) && read_setup_waits_i == 4'h1
		|-> mem_rd_n_o[*4] ##1 !mem_rd_n_o) else $error("read setup wrong");
	chk_rd_width: assert property (
		req_taken_o && !$past(req_write_i) && read_setup_waits_i == 4'h0
		&& read_active_waits_i == 4'h0 |-> !mem_rd_n_o[*4] ##1 rdata_valid_o)
		else $error("read strobe width wrong");
	chk_rd_hold: assert property (
		$rose(mem_rd_n_o) && read_hold_waits_i == 4'h1
		|-> $stable(mem_addr_o)[*4]) else $error("read address hold short");
	chk_rd_sample: assert property (
		rdata_valid_o |-> !$past(mem_rd_n_o))
		else $error("read data taken after strobe end");
	// ==========
	// Write strobe and idle address
	chk_wr_setup: assert property (
		req_taken_o && $past(req_write_i) && write_setup_waits_i == 4'h0
		&& write_active_waits_i == 4'h0 && turnaround_delay_ctl_i == 4'h0
		&& base_turnaround_delay_ctl_i == 4'h0
		|-> mem_wr_n_o ##1 mem_wr_n_o ##1 !mem_wr_n_o)
		else $error("write setup wrong");
	chk_wr_short: assert property (
		$fell(mem_wr_n_o) && write_active_waits_i == 4'h0 |=> mem_wr_n_o)
		else $error("short write strobe wrong");
	chk_wr_long: assert property (
		$fell(mem_wr_n_o) && write_active_waits_i == 4'h1
		|-> !mem_wr_n_o[*4] ##1 mem_wr_n_o) else $error("long strobe wrong");
	chk_wr_hold: assert property (
		$rose(mem_wr_n_o) && write_hold_waits_i == 4'h1 |-> (mem_data_oe_o
		&& $stable(mem_addr_o) && $stable(mem_data_o))[*5])
		else $error("write hold short");
	chk_idle_addr: assert property (
		!busy_o && !req_taken_o |-> $stable(mem_addr_o))
		else $error("address moved while idle");
endmodule

bind emt_bus_seq emt_bus_seq_sva u_emt_bus_seq_sva (.*);

// ==== verif/emt_bus_seq_tb.sv ====
// Self-checking bench for the external memory bus sequencer.
`timescale 1ns/1ns
module emt_bus_seq_tb;
	// ==========
	// Signals
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [3:0]  rss, ras, rsh, wss, was, wsh, trn, btr;
	reg         vld, wr, prd = 1'b1, pwr = 1'b1;
	reg  [20:0] a;
	reg  [15:0] d;
	wire        taken, busy, rv, oe, rd_n, wr_n;
	wire [15:0] rdata, mdo, mdi;
	wire [20:0] maddr;
	integer     num_errors = 0, tests_run = 0, cyc = 0;
	integer     gap = 0, hi = 0, nf = 0, n0;
	reg  [15:0] eq [$];

	always #4 clk = ~clk;

	emt_bus_seq u_emt_bus_seq (
		.core_clk_i(clk), .rst_n_i(rst_n),
		.read_setup_waits_i(rss), .read_active_waits_i(ras),
		.read_hold_waits_i(rsh), .write_setup_waits_i(wss),
		.write_active_waits_i(was), .write_hold_waits_i(wsh),
		.turnaround_delay_ctl_i(trn), .base_turnaround_delay_ctl_i(btr),
		.req_valid_i(vld), .req_write_i(wr), .req_addr_i(a),
		.req_wdata_i(d), .req_taken_o(taken), .busy_o(busy),
		.rdata_o(rdata), .rdata_valid_o(rv), .mem_addr_o(maddr),
		.mem_data_o(mdo), .mem_data_oe_o(oe), .mem_data_i(mdi),
		.mem_rd_n_o(rd_n), .mem_wr_n_o(wr_n));

	emt_mem_model #(.LAG(3)) u_emt_mem_model (
		.clk_i(clk), .addr_i(maddr), .data_i(mdo), .data_oe_i(oe),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .data_o(mdi));

	// ==========
	// Tasks
	task check(input [31:0] got, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task final_report;
	begin
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	// Reads always fetch the most recent write, so d is the expectation.
	task issue(input w);
	begin
		if (w) begin
			a <= a + 21'h00000B;
			d <= d + 16'h3C5A;
		end else begin
			eq.push_back(d);
		end
		wr <= w;
		vld <= 1'b1;
		@(posedge clk);
		while (taken !== 1'b1) @(posedge clk);
	end
	endtask

	task run(input [31:0] cfg, input w1, input w2, input [7:0] ehi,
		input [1:0] efall);
	begin
		{rss, ras, rsh, wss, was, wsh, trn, btr} <= cfg;
		@(posedge clk);
		n0 = nf;
		issue(w1);
		issue(w2);
		vld <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		repeat (2) @(posedge clk);
		check(nf - n0, efall);
		if (efall == 2'h2) check(hi, ehi);
		check(eq.size(), 32'h00000000);
	end
	endtask

	// ==========
	// Strobe gap monitor, read data and timeout
	// Counts high cycles between a strobe rise and the next fall.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prd <= rd_n;
		pwr <= wr_n;
		gap <= ((rd_n & ~prd) | (wr_n & ~pwr)) ? 0 : gap + 1;
		if ((~rd_n & prd) | (~wr_n & pwr)) begin
			hi <= gap + 1;
			nf <= nf + 1;
		end
		if (rv === 1'b1) check(rdata, eq.pop_front());
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end

	// ==========
	// Main sequence
	initial begin
		{rss, ras, rsh, wss, was, wsh, trn, btr} = 32'h00000000;
		vld = 1'b0;
		wr = 1'b0;
		a = 21'h000000;
		d = 16'h1234;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check({rd_n, wr_n, oe, busy}, 32'h0000000C);
		run(32'h00000000, 1'b1, 1'b1, 8'h03, 2'h2);
		run(32'h00001100, 1'b1, 1'b1, 8'h08, 2'h2);
		run(32'h10000100, 1'b1, 1'b0, 8'h09, 2'h2);
		run(32'h11100000, 1'b0, 1'b0, 8'h08, 2'h2);
		run(32'h00000000, 1'b0, 1'b0, 8'h00, 2'h1);
		run(32'h00010012, 1'b0, 1'b1, 8'h12, 2'h2);
		final_report;
	end
endmodule

// ==== verif/emt_mem_model.sv ====
// Behavioural asynchronous static memory on the far side of the bus.
`timescale 1ns/1ns
module emt_mem_model #(
	parameter LAG = 3
) (
	// Clock used only to pace the slow read answer
	input  wire        clk_i,
	// Bus pins seen from the memory
	input  wire [20:0] addr_i,
	input  wire [15:0] data_i,
	input  wire        data_oe_i,
	input  wire        rd_n_i,
	input  wire        wr_n_i,
	output wire [15:0] data_o
);
	reg [15:0] mem [0:255];
	reg [15:0] held = 16'h0000;
	integer    lo = 0;
	// A static part latches the word on the trailing strobe edge.
	always @(posedge wr_n_i) if (data_oe_i) mem[addr_i[7:0]] <= data_i;
	always @(posedge clk_i) begin
		lo <= rd_n_i ? 0 : lo + 1;
		held <= data_o;
	end
	// Slow part: the bus shows a moving pattern until LAG clocks in.
	assign data_o = (rd_n_i || lo < LAG) ? ~held : mem[addr_i[7:0]];
endmodule
